// [logic/scc_cfg.svh]
// constants for the sixteen channel capture/compare unit
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_NCH 16
`define SCC_TW 16
`define SCC_CNT_MAX 16'hFFFF
`define SCC_CNT_RST 16'h0000
`define SCC_PRE_W 8
`define SCC_PRE_RST 8'h00
`define SCC_STAG_LAST 3'h7
`define SCC_EDGE_RISE 2'h1
`define SCC_EDGE_FALL 2'h2
`define SCC_DBL_PAIRS 8
`define SCC_DBL_OFS 8
`endif

// [logic/scc_pkg.sv]
// types for the sixteen channel capture/compare unit
package scc_pkg;
	typedef enum logic [2:0] {
		SCC_OFF,
		SCC_CAPTURE,
		SCC_CMP0,
		SCC_CMP1,
		SCC_CMP2,
		SCC_CMP3
	} scc_mode_e;

	typedef enum logic [1:0] {
		SCC_SRC_PRESC,
		SCC_SRC_AUX,
		SCC_SRC_EXT
	} scc_src_e;

	typedef struct packed {
		logic [15:0] cnt;
		logic [7:0] pre;
		logic [2:0] stag;
		logic [2:0] sync;
		logic lvl;
		logic tick;
		logic ovf;
	} scc_tb_s;
endpackage : scc_pkg

// [logic/scc_tb_if.sv]
// link between the unit and one of its time bases
`timescale 1ns/1ns
interface scc_tb_if;
	logic run;
	logic [1:0] src;
	logic [2:0] psel;
	logic stag_en;
	logic [15:0] reload;
	logic aux_ovf;
	logic ext_in;
	logic [15:0] cnt;
	logic tick;
	logic ovf;

	modport timer (
		input run, src, psel, stag_en, reload, aux_ovf, ext_in,
		output cnt, tick, ovf
	);
	modport owner (
		output run, src, psel, stag_en, reload, aux_ovf, ext_in,
		input cnt, tick, ovf
	);
endinterface : scc_tb_if

// [logic/scc_timebase.sv]
// reloadable 16-bit time base with prescaler, aux and external count sources
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_timebase
	import scc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// owner side
	scc_tb_if.timer tb
);
	scc_tb_s st;
	scc_tb_s next_st;

	function automatic logic [7:0] pre_mask(input logic [2:0] sel);
		pre_mask = 8'((8'h01 << sel) - 8'h01);
	endfunction : pre_mask

	always_comb begin
		logic base;
		base = 1'b0;
		next_st = st;
		next_st.tick = 1'b0;
		next_st.ovf = 1'b0;
		// external count input: three stages, level taken when last two agree
		next_st.sync = {st.sync[1:0], tb.ext_in};
		if (st.sync[2] == st.sync[1]) begin
			next_st.lvl = st.sync[2];
		end
		if (tb.run) begin
			case (scc_src_e'(tb.src))
				SCC_SRC_PRESC: begin
					if (st.pre >= pre_mask(tb.psel)) begin
						next_st.pre = `SCC_PRE_RST;
						base = 1'b1;
					end else begin
						next_st.pre = 8'(st.pre + 8'h01);
					end
				end
				SCC_SRC_AUX: base = tb.aux_ovf;
				SCC_SRC_EXT: base = next_st.lvl & ~st.lvl;
				default: base = 1'b0;
			endcase
		end
		// staggered operation: one count per eight base ticks
		if (base && tb.stag_en) begin
			next_st.stag = 3'(st.stag + 3'h1);
			base = (st.stag == `SCC_STAG_LAST);
		end
		if (base) begin
			next_st.tick = 1'b1;
			if (st.cnt == `SCC_CNT_MAX) begin
				next_st.cnt = tb.reload;
				next_st.ovf = 1'b1;
			end else begin
				next_st.cnt = 16'(st.cnt + 16'h0001);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tb.cnt = st.cnt;
	assign tb.tick = st.tick;
	assign tb.ovf = st.ovf;
endmodule : scc_timebase

// [logic/scc_unit.sv]
// sixteen channel capture/compare array with two time bases
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_unit
	import scc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// time base 0 setup
	input wire logic t0_run,
	input wire logic [1:0] t0_src,
	input wire logic [2:0] t0_psel,
	input wire logic [15:0] t0_reload,
	input wire logic t0_ext_in,
	// time base 1 setup
	input wire logic t1_run,
	input wire logic [1:0] t1_src,
	input wire logic [2:0] t1_psel,
	input wire logic [15:0] t1_reload,
	input wire logic t1_ext_in,
	// shared timing options
	input wire logic stag_en,
	input wire logic auxiliary_gp_timer_ovf,
	// channel setup
	input wire logic [15:0][2:0] ch_mode,
	input wire logic [15:0] ch_tmr,
	input wire logic [15:0][1:0] ch_edge,
	input wire logic [15:0] ch_single,
	input wire logic [7:0] ch_dbl,
	// register write and read
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [3:0] rd_idx,
	output logic [15:0] rd_data,
	// pins and events
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	output logic [15:0] irq,
	output logic [1:0] tmr_ovf
);
	typedef struct packed {
		logic [15:0][15:0] ccr;
		logic [15:0] ps1;
		logic [15:0] ps2;
		logic [15:0] ps3;
		logic [15:0] plvl;
		logic [15:0] pout;
		logic [15:0] poe;
		logic [15:0] irq;
		logic [15:0] done;
		logic [15:0] se_lock;
		logic [15:0] rd;
		logic [1:0] ovf;
	} scc_unit_s;

	scc_unit_s st;
	scc_unit_s next_st;

	scc_tb_if tb0 ();
	scc_tb_if tb1 ();

	assign tb0.run = t0_run;
	assign tb0.src = t0_src;
	assign tb0.psel = t0_psel;
	assign tb0.stag_en = stag_en;
	assign tb0.reload = t0_reload;
	assign tb0.aux_ovf = auxiliary_gp_timer_ovf;
	assign tb0.ext_in = t0_ext_in;
	assign tb1.run = t1_run;
	assign tb1.src = t1_src;
	assign tb1.psel = t1_psel;
	assign tb1.stag_en = stag_en;
	assign tb1.reload = t1_reload;
	assign tb1.aux_ovf = auxiliary_gp_timer_ovf;
	assign tb1.ext_in = t1_ext_in;

	scc_timebase u_tb0 (
		.clk(clk),
		.rst_b(rst_b),
		.tb(tb0.timer)
	);

	scc_timebase u_tb1 (
		.clk(clk),
		.rst_b(rst_b),
		.tb(tb1.timer)
	);

	function automatic logic edge_hit(input logic [1:0] sel, input logic old_lvl, input logic new_lvl);
		edge_hit = ((sel & `SCC_EDGE_RISE) != 2'h0 && !old_lvl && new_lvl) ||
			((sel & `SCC_EDGE_FALL) != 2'h0 && old_lvl && !new_lvl);
	endfunction : edge_hit

	function automatic logic is_compare(input scc_mode_e m);
		is_compare = (m == SCC_CMP0) || (m == SCC_CMP1) || (m == SCC_CMP2) || (m == SCC_CMP3);
	endfunction : is_compare

	always_comb begin
		logic [15:0] cnt;
		logic tick;
		logic ovf;
		logic [15:0] match;
		logic [15:0] ovf_ch;
		logic [15:0] cnt_ch [16];
		logic [15:0] lvl_now;
		logic act;
		scc_mode_e m;
		cnt = '0;
		tick = 1'b0;
		ovf = 1'b0;
		match = '0;
		ovf_ch = '0;
		lvl_now = st.plvl;
		act = 1'b0;
		m = SCC_OFF;
		for (int k = 0; k < `SCC_NCH; k++) begin
			cnt_ch[k] = '0;
		end
		next_st = st;
		next_st.irq = '0;
		next_st.ovf = {tb1.ovf, tb0.ovf};
		// pin inputs: three stages, level taken when last two agree
		next_st.ps1 = pin_in;
		next_st.ps2 = st.ps1;
		next_st.ps3 = st.ps2;
		for (int i = 0; i < `SCC_NCH; i++) begin
			if (st.ps2[i] == st.ps3[i]) begin
				lvl_now[i] = st.ps3[i];
			end
		end
		next_st.plvl = lvl_now;
		// software write first so that a capture in the same cycle wins
		if (wr_en) begin
			next_st.ccr[wr_idx] = wr_data;
		end
		// per-channel timer view and match detection
		for (int i = 0; i < `SCC_NCH; i++) begin
			cnt = ch_tmr[i] ? tb1.cnt : tb0.cnt;
			tick = ch_tmr[i] ? tb1.tick : tb0.tick;
			ovf = ch_tmr[i] ? tb1.ovf : tb0.ovf;
			cnt_ch[i] = cnt;
			ovf_ch[i] = ovf;
			match[i] = tick && (cnt == st.ccr[i]) && is_compare(scc_mode_e'(ch_mode[i]));
		end
		for (int i = 0; i < `SCC_NCH; i++) begin
			m = scc_mode_e'(ch_mode[i]);
			// once-per-period lockout released at overflow; a match in that cycle wins only if the lockout was already clear
			if (ovf_ch[i]) begin
				next_st.done[i] = 1'b0;
			end
			if (!ch_single[i]) begin
				next_st.se_lock[i] = 1'b0;
			end
			act = match[i] && !(ch_single[i] && st.se_lock[i]);
			next_st.poe[i] = (m == SCC_CMP1) || (m == SCC_CMP3);
			case (m)
				SCC_CAPTURE: begin
					if (edge_hit(ch_edge[i], st.plvl[i], lvl_now[i])) begin
						next_st.ccr[i] = cnt_ch[i];
						next_st.irq[i] = 1'b1;
					end
				end
				SCC_CMP0: begin
					if (act) begin
						next_st.irq[i] = 1'b1;
						next_st.se_lock[i] = 1'b1;
					end
				end
				SCC_CMP1: begin
					if (act) begin
						next_st.pout[i] = ~st.pout[i];
						next_st.irq[i] = 1'b1;
						next_st.se_lock[i] = 1'b1;
					end
				end
				SCC_CMP2: begin
					if (act && !st.done[i]) begin
						next_st.irq[i] = 1'b1;
						next_st.done[i] = 1'b1;
						next_st.se_lock[i] = 1'b1;
					end
				end
				SCC_CMP3: begin
					if (ovf_ch[i]) begin
						next_st.pout[i] = 1'b0;
					end
					if (act && !st.done[i]) begin
						next_st.pout[i] = 1'b1;
						next_st.irq[i] = 1'b1;
						next_st.done[i] = 1'b1;
						next_st.se_lock[i] = 1'b1;
					end
				end
				default: next_st.poe[i] = 1'b0;
			endcase
		end
		// double register: upper partner toggles the lower pin, its own pin idle
		for (int i = 0; i < `SCC_DBL_PAIRS; i++) begin
			if (ch_dbl[i]) begin
				next_st.poe[i + `SCC_DBL_OFS] = 1'b0;
				next_st.poe[i] = is_compare(scc_mode_e'(ch_mode[i]));
				next_st.pout[i + `SCC_DBL_OFS] = 1'b0;
				if (match[i + `SCC_DBL_OFS] &&
					!(ch_single[i + `SCC_DBL_OFS] && st.se_lock[i + `SCC_DBL_OFS])) begin
					next_st.pout[i] = ~next_st.pout[i];
				end
			end
		end
		next_st.rd = next_st.ccr[rd_idx];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd;
	assign pin_out = st.pout;
	assign pin_oe = st.poe;
	assign irq = st.irq;
	assign tmr_ovf = st.ovf;
endmodule : scc_unit

// [bench/scc_unit_monitor.sv]
// assertions on the capture/compare unit ports
`timescale 1ns/1ns
module scc_unit_monitor (
	// watched ports
	input wire logic clk,
	input wire logic rst_b,
	input wire logic t0_run,
	input wire logic [15:0] t0_reload,
	input wire logic [15:0][2:0] ch_mode,
	input wire logic [15:0][1:0] ch_edge,
	input wire logic [15:0] ch_single,
	input wire logic [7:0] ch_dbl,
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [3:0] rd_idx,
	input wire logic [15:0] rd_data,
	input wire logic [15:0] pin_in,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] irq,
	input wire logic [1:0] tmr_ovf
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_irq_src;
		irq[1] |-> $past(ch_mode[1]) inside {[3'h1:3'h5]};
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq on idle channel");
	property p_ovf_pulse;
		tmr_ovf[0] && t0_reload != 16'hFFFF |=> !tmr_ovf[0];
	endproperty
	a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
	property p_run_hold;
		(!t0_run)[*3] |-> !tmr_ovf[0];
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("overflow while stopped");
	property p_cmp3_clr;
		tmr_ovf[0] && ch_mode[0] == 3'h5 && !ch_single[0] && !ch_dbl[0] |-> !pin_out[0] || irq[0];
	endproperty
	a_cmp3_clr: assert property (p_cmp3_clr) else $error("pin not cleared at overflow");
	property p_cmp0_pin;
		ch_mode[1] == 3'h2 && $past(ch_mode[1]) == 3'h2 && !ch_dbl[1] |-> $stable(pin_out[1]);
	endproperty
	a_cmp0_pin: assert property (p_cmp0_pin) else $error("pin moved in interrupt mode");
	property p_cap_lat;
		$rose(pin_in[2]) && ch_mode[2] == 3'h1 && ch_edge[2][0] ##1 pin_in[2][*3] |-> ##[0:2] irq[2];
	endproperty
	a_cap_lat: assert property (p_cap_lat) else $error("capture late");
	property p_cap_edge;
		$fell(pin_in[2]) && ch_mode[2] == 3'h1 && ch_edge[2] == 2'h1 |-> (!irq[2])[*6];
	endproperty
	a_cap_edge: assert property (p_cap_edge) else $error("capture on wrong edge");
	property p_wr_rd;
		wr_en && wr_idx == rd_idx && ch_mode[wr_idx] != 3'h1 |=> rd_data == $past(wr_data);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("write not seen");
endmodule : scc_unit_monitor
bind scc_unit scc_unit_monitor i_scc_unit_monitor (.*);

// [bench/scc_pins.sv]
// external pin and count-input driver
`timescale 1ns/1ns
module scc_pins (
	// clock and requests
	input wire logic clk,
	input wire logic [15:0] lvl,
	// pins
	output logic [15:0] pin_in,
	output logic t0_ext_in
);
	logic [1:0] ph = 2'h0;
	initial pin_in = 16'h0000;
	initial t0_ext_in = 1'h0;
	// levels held four cycles
	always @(negedge clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			pin_in <= lvl;
			t0_ext_in <= ~t0_ext_in;
		end
	end
endmodule : scc_pins

// [bench/tb_scc_unit.sv]
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
module tb_scc_unit;
	logic clk = 1'h0, rst_b = 1'h0, t0_run = 1'h0, t1_run = 1'h0, stag_en = 1'h0;
	logic wr_en = 1'h0, t1_ext_in = 1'h0, auxiliary_gp_timer_ovf = 1'h0;
	logic [1:0] t0_src = 2'h0, t1_src = 2'h0, tmr_ovf;
	logic [2:0] t0_psel = 3'h0, t1_psel = 3'h0;
	logic [15:0] t0_reload = 16'hFFF0, t1_reload = 16'h0000, ch_tmr = 16'h0000, ch_single = 16'h0010;
	logic [15:0][2:0] ch_mode = '0;
	logic [15:0][1:0] ch_edge = '0;
	logic [7:0] ch_dbl = 8'h00;
	logic [3:0] wr_idx = 4'h0, rd_idx = 4'h0;
	logic [15:0] wr_data = 16'h0000, lvl = 16'h0000, pin_in, rd_data, pin_out, pin_oe, irq, pp;
	logic t0_ext_in;
	logic [31:0] seed = 32'h7B87A72F;
	int mismatches = 0, checks_done = 0;
	int n[6];
	int ex[6] = '{4, 4, 1, 1, 4, 2};
	always #50 clk = ~clk;
	scc_pins i_scc_pins (.clk(clk), .lvl(lvl), .pin_in(pin_in), .t0_ext_in(t0_ext_in));
	scc_unit i_scc_unit (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] adv(input logic [15:0] c, input int k, input logic [15:0] r);
		for (int j = 0; j < k; j++) c = (c == 16'hFFFF) ? r : 16'(c + 16'h0001);
		return c;
	endfunction : adv
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic wr(input logic [3:0] i, input logic [15:0] d);
		@(negedge clk);
		wr_en = 1'h1;
		wr_idx = i;
		rd_idx = i;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'h0;
		check(rd_data, d);
	endtask : wr
	task automatic wait_ovf;
		int k;
		k = 0;
		@(negedge clk);
		while (tmr_ovf[0] !== 1'h1 && k < 70000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 70000) begin
			mismatches++;
			final_report();
		end
	endtask : wait_ovf
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'h1;
		check(irq | pin_out, 16'h0000);
		wr(4'hF, 16'hA55A);
		wr(4'h0, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(seed[3:0], seed[31:16]);
		end
		$display("test write/read done");
		wr(4'h0, 16'hFFF8);
		wr(4'h1, 16'hFFF4);
		wr(4'h3, 16'hFFF2);
		wr(4'h4, 16'hFFF6);
		ch_mode[4:0] = {3'h4, 3'h3, 3'h1, 3'h2, 3'h5};
		ch_edge[2] = 2'h1;
		t1_run = 1'h1;
		t0_run = 1'h1;
		wait_ovf();
		t0_psel = {2'h0, seed[0]};
		wait_ovf();
		wait_ovf();
		// release the single-event lock taken before the window
		ch_single[4] = 1'h0;
		@(negedge clk);
		ch_single[4] = 1'h1;
		pp = pin_out;
		for (int c = 0; c < (64 << t0_psel); c++) begin
			@(negedge clk);
			lvl[2] = (c >= 8 && c < 40);
			n[0] += tmr_ovf[0];
			n[1] += irq[1];
			n[2] += irq[2];
			n[3] += irq[4];
			n[4] += pin_out[0] & ~pp[0];
			n[5] += pin_out[3] & ~pp[3];
			pp = pin_out;
		end
		for (int i = 0; i < 6; i++) check(16'(n[i]), 16'(ex[i]));
		check({pin_oe[3], pin_oe[1]}, 16'h0002);
		rd_idx = 4'h2;
		repeat (2) @(negedge clk);
		check(16'(rd_data >= 16'hFFF0), 16'h0001);
		$display("test compare/capture done");
		t0_run = 1'h0;
		n[0] = 0;
		repeat (40) begin
			@(negedge clk);
			n[0] += tmr_ovf[0];
		end
		check(16'(n[0]), 16'h0000);
		$display("test stop done");
		// count from auxiliary overflow pulses, measured by captures on both edges
		t0_src = 2'h1;
		t0_run = 1'h1;
		ch_edge[2] = 2'h3;
		rd_idx = 4'h2;
		lvl[2] = 1'h1;
		repeat (12) @(negedge clk);
		pp = rd_data;
		for (int c = 0; c < 10; c++) begin
			auxiliary_gp_timer_ovf = ~auxiliary_gp_timer_ovf;
			@(negedge clk);
		end
		lvl[2] = 1'h0;
		repeat (12) @(negedge clk);
		check(rd_data, adv(pp, 5, t0_reload));
		$display("test auxiliary source done");
		final_report();
	end
endmodule : tb_scc_unit
